// >>> inc/dbg_pkg.sv
// Purpose : Shared constants for the debug control and break logic
// Assumes : 8-bit debug control word in the low byte of a 32-bit Avalon word
// Notes   : Offsets are byte addresses on the register bus
package dbg_pkg;

  // Avalon register map (byte addresses)
  localparam logic [3:0] OFS_CONTROL  = 4'h0;
  localparam logic [3:0] OFS_STATUS   = 4'h4;
  localparam logic [3:0] OFS_SECURITY = 4'h8;

  // Debug control word fields
  localparam int BIT_MODULE_ON  = 7;
  localparam int BIT_RUN_ARM    = 6;
  localparam int BIT_TAG_SEL    = 5;
  localparam int BIT_BRK_GATE   = 4;
  localparam int BIT_A_DIR      = 3;
  localparam int BIT_A_QUALIFY  = 2;
  localparam int BIT_B_DIR      = 1;
  localparam int BIT_B_QUALIFY  = 0;

  // Status word fields
  localparam int BIT_A_MATCH    = 7;
  localparam int BIT_B_MATCH    = 6;
  localparam int BIT_RUN_FLAG   = 5;

  // Background status/control fields
  localparam int BIT_BG_PERMIT  = 7;
  localparam int BIT_BG_ACTIVE  = 6;
  localparam int BIT_BG_CLKSEL  = 2;
  localparam int BIT_WS_STATUS  = 4;
  localparam int BIT_WS_FLAG    = 3;
  localparam int BIT_DV_FAIL    = 1;
  localparam logic [7:0] BG_WRITABLE_MASK = 8'h84;

  // Reset values and FIFO full count
  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam logic [7:0]  BG_SC_RESET   = 8'h00;
  localparam logic [15:0] BG_BKPT_RESET = 16'h0000;
  localparam logic [3:0]  FIFO_FULL_CNT = 4'h8;

  // Serial debug command codes
  localparam logic [1:0] CMD_WRITE_CONTROL = 2'h1;
  localparam logic [1:0] CMD_WRITE_BKPT    = 2'h2;

  // Break kinds
  typedef enum logic [1:0] {BRK_NONE, BRK_FORCE, BRK_TAG, BRK_SWI} brk_kind_e;

endpackage

// >>> sim/cpu_host_model.sv
// Purpose : CPU core and serial debug host facing the break logic
// Assumes : Host commands are one-cycle pulses on the bus clock
// Notes   : Enters background only after a granted break, left by resume
`timescale 1ns/1ps
`default_nettype none
module cpu_host_model
(
  input  wire logic        clock,
  input  wire logic        break_force,
  input  wire logic        break_tag,
  input  wire logic [7:0]  bg_sc_read,
  output logic             cmd_valid,
  output logic [1:0]       cmd_code,
  output logic [15:0]      cmd_data,
  output logic             bg_active_status,
  output logic             wait_stop_status,
  output logic             wait_stop_flag,
  output logic             data_valid_failure
);
  logic [2:0] delay_reg;

  // Quiet host and running CPU at time zero
  initial
  begin
    {cmd_valid, cmd_code, cmd_data, delay_reg} = '0;
    {bg_active_status, wait_stop_status, wait_stop_flag, data_valid_failure} = '0;
  end

  // Force finishes the instruction, tag waits for the opcode to leave the pipe
  always @(posedge clock)
  begin
    if (delay_reg != 3'h0)
    begin
      delay_reg <= delay_reg - 3'h1;
      if (delay_reg == 3'h1)
        bg_active_status <= 1'b1;
    end
    else if (bg_sc_read[7] && break_force)
      delay_reg <= 3'h2;
    else if (bg_sc_read[7] && break_tag)
      delay_reg <= 3'h3;
  end

  // Background registers are only reached through serial commands
  task automatic send(input logic [1:0] code, input logic [15:0] data);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_code  <= code;
    cmd_data  <= data;
    @(posedge clock);
    cmd_valid <= 1'b0;
    cmd_data  <= ~data; // Stale data never repeats the last word
  endtask

  // Wait/stop and data-valid levels of the CPU
  task automatic flags(input logic [2:0] f);
    @(posedge clock);
    {wait_stop_status, wait_stop_flag, data_valid_failure} <= f;
  endtask

  // Host resumes the user program
  task automatic resume;
    @(posedge clock);
    bg_active_status <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> sim/tb_debug_break_ctrl.sv
// Purpose : Self-checking bench for the debug control and break logic
// Assumes : Avalon slave paced by waitrequest, registered outputs
// Notes   : Break pulses are watched for ten cycles after each cause
`timescale 1ns/1ps
`default_nettype none
module tb_debug_break_ctrl;
  import dbg_pkg::*;
  logic        clock, rst, read, write, waitrequest, secured, bus_rnw;
  logic [3:0]  address;
  logic [31:0] writedata, readdata, rd;
  logic        cmd_valid, bg_active_status, wait_stop_status, wait_stop_flag;
  logic        data_valid_failure, cmp_a_raw, cmp_b_raw, trigger_event, begin_trace;
  logic        fifo_push, opcode_fetch_trigger_sel, cmp_a_hit, cmp_b_hit, fifo_store_en;
  logic        break_force, break_tag, software_interrupt_op, ex;
  logic [1:0]  cmd_code;
  logic [15:0] cmd_data, bg_bkpt_read;
  logic [7:0]  bg_sc_read;
  logic [2:0]  seen;
  int          bad_count, compares, cycles, lat, lat0;

  debug_break_ctrl dut_u (.clock, .rst, .address, .read, .write, .writedata, .readdata,
    .waitrequest, .cmd_valid, .cmd_code, .cmd_data, .bg_sc_read, .bg_bkpt_read, .secured,
    .bg_active_status, .wait_stop_status, .wait_stop_flag, .data_valid_failure, .bus_rnw,
    .cmp_a_raw, .cmp_b_raw, .trigger_event, .begin_trace, .fifo_push,
    .opcode_fetch_trigger_sel, .cmp_a_hit, .cmp_b_hit, .fifo_store_en, .break_force,
    .break_tag, .software_interrupt_op);

  cpu_host_model host_u (.clock, .break_force, .break_tag, .bg_sc_read, .cmd_valid,
    .cmd_code, .cmd_data, .bg_active_status, .wait_stop_status, .wait_stop_flag,
    .data_valid_failure);

  ////////////////////////////////////////////////////////////////////////////////
  // Compare, bus access and break watching
  task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
    compares++;
    if (seen_v !== exp_v)
    begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
    end
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    address   <= a;
    writedata <= {24'h0, d};
    write     <= wr;
    read      <= ~wr;
    @(posedge clock);
    while (waitrequest !== 1'b0)
      @(posedge clock);
    rd = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    check(rd, {24'h0, e});
  endtask

  task automatic watch;
    seen = 3'b000;
    lat  = -1;
    for (int i = 0; i < 10; i++)
    begin
      @(negedge clock);
      if ({break_force, break_tag, software_interrupt_op} !== 3'b000 && lat < 0)
        lat = i;
      seen = seen | {break_force, break_tag, software_interrupt_op};
    end
  endtask

  task automatic fire;
    @(posedge clock);
    trigger_event <= 1'b1;
    @(posedge clock);
    trigger_event <= 1'b0;
    watch;
  endtask

  task automatic push(input int n);
    repeat (n)
    begin
      @(posedge clock);
      fifo_push <= 1'b1;
      @(posedge clock);
      fifo_push <= 1'b0;
    end
  endtask

  task automatic close_out;
    $display("counts: compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      close_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial
  begin
    {read, write, secured, bus_rnw, address, writedata, cmp_a_raw, cmp_b_raw} = '0;
    {trigger_event, begin_trace, fifo_push, opcode_fetch_trigger_sel} = '0;
    rst = 1'b1;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    // Map, reset value, refused places
    rchk(OFS_CONTROL, 8'h00);
    bus(1'b1, OFS_STATUS, 8'hff);
    rchk(OFS_STATUS, 8'h00);
    bus(1'b1, 4'hc, 8'hff);
    rchk(4'hc, 8'h00);
    bus(1'b1, OFS_CONTROL, 8'h2f);
    rchk(OFS_CONTROL, 8'h2f);
    $display("test map done");
    // Enable refused while secured
    secured <= 1'b1;
    repeat (3) @(posedge clock);
    bus(1'b1, OFS_CONTROL, 8'h80);
    rchk(OFS_CONTROL, 8'h00);
    secured <= 1'b0;
    repeat (4) @(posedge clock);
    bus(1'b1, OFS_CONTROL, 8'h80);
    rchk(OFS_CONTROL, 8'h80);
    $display("test secure done");
    // Direction qualification, every setting against both bus directions
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b1, OFS_CONTROL, {4'h8, i[2], i[1], i[2], i[1]});
      cmp_a_raw <= 1'b1;
      cmp_b_raw <= 1'b1;
      bus_rnw   <= i[0];
      repeat (3) @(negedge clock);
      ex = ~i[1] | (i[2] == i[0]);
      check({cmp_a_hit, cmp_b_hit}, {ex, ex});
    end
    @(posedge clock);
    cmp_a_raw <= 1'b0;
    cmp_b_raw <= 1'b0;
    repeat (3) @(negedge clock);
    check({cmp_a_hit, cmp_b_hit}, 2'b00);
    $display("test qualify done");
    // Background registers
    host_u.send(CMD_WRITE_CONTROL, 16'h00ff);
    repeat (3) @(negedge clock);
    check(bg_sc_read, 8'h84);
    host_u.flags(3'b111);
    repeat (3) @(negedge clock);
    check(bg_sc_read, 8'h9e);
    host_u.send(CMD_WRITE_CONTROL, 16'h0000);
    host_u.send(CMD_WRITE_BKPT, 16'ha5c3);
    repeat (3) @(negedge clock);
    check(bg_sc_read, 8'h1a);
    check(bg_bkpt_read, 16'ha5c3);
    host_u.flags(3'b000);
    $display("test background done");
    // Armed run without background permit
    bus(1'b1, OFS_CONTROL, 8'hd0);
    rchk(OFS_STATUS, 8'h20);
    check(fifo_store_en, 1'b1);
    fire;
    check(seen, 3'b101);
    rchk(OFS_CONTROL, 8'h90);
    $display("test swi done");
    // Force break, then permit frozen in background
    host_u.send(CMD_WRITE_CONTROL, 16'h0080);
    bus(1'b1, OFS_CONTROL, 8'hd0);
    fire;
    lat0 = lat;
    check(seen, 3'b100);
    host_u.send(CMD_WRITE_CONTROL, 16'h0004);
    repeat (3) @(negedge clock);
    check(bg_sc_read, 8'hc4);
    host_u.resume;
    $display("test force done");
    // Tag break with opcode-fetch select, same timing
    opcode_fetch_trigger_sel <= 1'b1;
    bus(1'b1, OFS_CONTROL, 8'hf0);
    fire;
    check(seen, 3'b010);
    check(lat, lat0);
    host_u.resume;
    $display("test tag done");
    // Gate off: run ends, storage on, no break
    bus(1'b1, OFS_CONTROL, 8'he0);
    repeat (2) @(negedge clock);
    check(fifo_store_en, 1'b1);
    fire;
    check(seen, 3'b000);
    rchk(OFS_CONTROL, 8'ha0);
    $display("test gate done");
    // Begin trace breaks on the eighth word
    begin_trace <= 1'b1;
    bus(1'b1, OFS_CONTROL, 8'hd0);
    push(7);
    watch;
    check(seen, 3'b000);
    push(1);
    watch;
    check(seen, 3'b100);
    rchk(OFS_STATUS, {4'h0, FIFO_FULL_CNT});
    begin_trace <= 1'b0;
    host_u.resume;
    $display("test begin trace done");
    // Match flags while armed, manual stop by arm or enable cleared
    bus(1'b1, OFS_CONTROL, 8'hd0);
    cmp_a_raw <= 1'b1;
    cmp_b_raw <= 1'b1;
    rchk(OFS_STATUS, 8'he0);
    cmp_a_raw <= 1'b0;
    cmp_b_raw <= 1'b0;
    bus(1'b1, OFS_CONTROL, 8'h90);
    repeat (2) @(negedge clock);
    check(fifo_store_en, 1'b0);
    rchk(OFS_STATUS, 8'hc0);
    bus(1'b1, OFS_CONTROL, 8'hd0);
    rchk(OFS_STATUS, 8'h20);
    bus(1'b1, OFS_CONTROL, 8'h50);
    fire;
    check(seen, 3'b000);
    $display("test stop done");
    close_out;
  end
endmodule
`default_nettype wire

// >>> src/bg_regs.sv
// Purpose : Background controller status/control and breakpoint registers
// Assumes : Reached only by serial debug commands, never by the user bus
// Notes   : Status bits are inputs, never written
`timescale 1ns/1ps
`default_nettype none
module bg_regs
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        cmd_valid,
  input  wire logic [1:0]  cmd_code,
  input  wire logic [15:0] cmd_data,
  input  wire logic        bg_active_status,
  input  wire logic        wait_stop_status,
  input  wire logic        wait_stop_flag,
  input  wire logic        data_valid_failure,
  output logic [7:0]       bg_status_control_reg,
  output logic [15:0]      bg_breakpoint_match_reg
);
  import dbg_pkg::*;

  logic [7:0] ctl_reg;
  logic [7:0] mask;

  // Permit bit frozen while in active background mode
  assign mask = bg_active_status ? (BG_WRITABLE_MASK & ~(8'h01 << BIT_BG_PERMIT))
                                 : BG_WRITABLE_MASK;

  // Control bits written by serial command only
  always_ff @(posedge clock)
  begin
    if (rst)
      ctl_reg <= BG_SC_RESET;
    else if (cmd_valid && cmd_code == CMD_WRITE_CONTROL)
      ctl_reg <= (ctl_reg & ~mask) | (cmd_data[7:0] & mask); // R3 R4 R5
  end

  // Breakpoint address written by serial command only
  always_ff @(posedge clock)
  begin
    if (rst)
      bg_breakpoint_match_reg <= BG_BKPT_RESET;
    else if (cmd_valid && cmd_code == CMD_WRITE_BKPT)
      bg_breakpoint_match_reg <= cmd_data; // R1 R2
  end

  // Read image with live status bits
  always_comb
  begin
    bg_status_control_reg = ctl_reg; // R1
    bg_status_control_reg[BIT_BG_ACTIVE] = bg_active_status; // R4
    bg_status_control_reg[BIT_WS_STATUS] = wait_stop_status;
    bg_status_control_reg[BIT_WS_FLAG]   = wait_stop_flag;
    bg_status_control_reg[BIT_DV_FAIL]   = data_valid_failure;
  end

  a_permit_frozen: assert property (@(posedge clock) disable iff (rst) // R3
    bg_active_status && $past(bg_active_status) && !$past(rst)
      |-> ctl_reg[BIT_BG_PERMIT] == $past(ctl_reg[BIT_BG_PERMIT]))
    else $error("permit bit changed in background mode");
endmodule
`default_nettype wire

// >>> src/cmp_qualify.sv
// Purpose : Qualify one comparator match with bus direction
// Assumes : rnw high is a read cycle
// Notes   : Combinational
`timescale 1ns/1ps
`default_nettype none
module cmp_qualify
(
  input  wire logic raw_match,
  input  wire logic rnw,
  input  wire logic dir_sel,
  input  wire logic qualify,
  output logic      hit
);
  // Direction only counts when qualification is on
  assign hit = raw_match & (~qualify | (dir_sel == rnw));
endmodule
`default_nettype wire

// >>> src/debug_break_ctrl.sv
// Overview of operation
// R1: Background block holds 8-bit and 16-bit registers
// R2: Background registers reachable only by serial commands
// R3: Permit bit frozen during active background mode
// R4: Four background status bits are read-only
// R5: Clock source select writable at any time
// R6: Control register accessible at any time
// R7: Bit 7 enables module; blocked when secured
// R8: Bit 6 arms run, clears when run ends
// R9: Writing 0 to arm or enable stops run
// R10: Bit 5 picks tag or force break
// R11: Bit 4 gates break requests to CPU
// R12: Triggers store FIFO data without breaking
// R13: End trace breaks on trigger, begin on full
// R14: Opcode-fetch select leaves break timing unchanged
// R15: Bit 3 picks comparator A direction
// R16: Bit 2 enables comparator A qualification
// R17: Bit 1 picks comparator B direction
// R18: Bit 0 enables comparator B qualification
// R19: Arming sets run flag, clears match flags, count
// R20: Force finishes instruction; tag marks opcode
// R21: Without background permit, break runs software interrupt
//
// Purpose : Debug control register, run arming and CPU break requests
// Assumes : Avalon-MM slave with waitrequest; comparators and FIFO outside
// Notes   : Every read or write answers one cycle after it is raised
`timescale 1ns/1ps
`default_nettype none
module debug_break_ctrl
(
  input  wire logic        clock,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // Serial debug command port
  input  wire logic        cmd_valid,
  input  wire logic [1:0]  cmd_code,
  input  wire logic [15:0] cmd_data,
  output logic [7:0]       bg_sc_read,
  output logic [15:0]      bg_bkpt_read,
  // CPU and security state
  input  wire logic        secured,
  input  wire logic        bg_active_status,
  input  wire logic        wait_stop_status,
  input  wire logic        wait_stop_flag,
  input  wire logic        data_valid_failure,
  input  wire logic        bus_rnw,
  // Comparator and FIFO datapath
  input  wire logic        cmp_a_raw,
  input  wire logic        cmp_b_raw,
  input  wire logic        trigger_event,
  input  wire logic        begin_trace,
  input  wire logic        fifo_push,
  input  wire logic        opcode_fetch_trigger_sel,
  output logic             cmp_a_hit,
  output logic             cmp_b_hit,
  output logic             fifo_store_en,
  output logic             break_force,
  output logic             break_tag,
  output logic             software_interrupt_op
);
  import dbg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0]  debug_control_reg;
  logic [7:0]  bg_sc;
  logic [15:0] bg_bkpt;
  logic        cmp_a_match_flag;
  logic        cmp_b_match_flag;
  logic [3:0]  fifo_valid_words;
  logic        a_q;
  logic        b_q;
  logic        sec_s1_reg;
  logic        sec_s2_reg;
  logic        ack_reg;
  logic        wr_ctl;
  logic        run_done;
  logic        armed;
  logic        fifo_full;
  logic        brk_cause;
  logic [7:0]  ctl_next;

  ////////////////////////////////////////////////////////////////////////////
  // Background registers
  bg_regs u_bg
  (
    .clock                   (clock),
    .rst                     (rst),
    .cmd_valid               (cmd_valid),
    .cmd_code                (cmd_code),
    .cmd_data                (cmd_data),
    .bg_active_status        (bg_active_status),
    .wait_stop_status        (wait_stop_status),
    .wait_stop_flag          (wait_stop_flag),
    .data_valid_failure      (data_valid_failure),
    .bg_status_control_reg   (bg_sc),
    .bg_breakpoint_match_reg (bg_bkpt)
  );

  // Registered serial read image; no bus address maps here
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      bg_sc_read   <= BG_SC_RESET;
      bg_bkpt_read <= BG_BKPT_RESET;
    end
    else
    begin
      bg_sc_read   <= bg_sc;   // R2
      bg_bkpt_read <= bg_bkpt; // R2
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Security pin synchroniser
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sec_s1_reg <= 1'b1;
      sec_s2_reg <= 1'b1;
    end
    else
    begin
      sec_s1_reg <= secured;
      sec_s2_reg <= sec_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon handshake: one wait cycle, then acknowledge
  always_ff @(posedge clock)
  begin
    if (rst)
      ack_reg <= 1'b0;
    else
      ack_reg <= (read | write) & ~ack_reg; // R6
  end

  assign wr_ctl = write & ack_reg & (address == OFS_CONTROL);

  // Waitrequest idles high and drops only in the acknowledge cycle
  always_ff @(posedge clock)
  begin
    if (rst)
      waitrequest <= 1'b1;
    else
      waitrequest <= ~((read | write) & ~ack_reg); // R6
  end

  ////////////////////////////////////////////////////////////////////////////
  // Qualified comparators
  cmp_qualify u_qa
  (
    .raw_match (cmp_a_raw),
    .rnw       (bus_rnw),
    .dir_sel   (debug_control_reg[BIT_A_DIR]),     // R15
    .qualify   (debug_control_reg[BIT_A_QUALIFY]), // R16
    .hit       (a_q)
  );

  cmp_qualify u_qb
  (
    .raw_match (cmp_b_raw),
    .rnw       (bus_rnw),
    .dir_sel   (debug_control_reg[BIT_B_DIR]),     // R17
    .qualify   (debug_control_reg[BIT_B_QUALIFY]), // R18
    .hit       (b_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Run state
  assign armed     = debug_control_reg[BIT_MODULE_ON] & debug_control_reg[BIT_RUN_ARM];
  assign fifo_full = fifo_valid_words == FIFO_FULL_CNT;
  // End of run: trigger in end trace, full FIFO in begin trace
  assign run_done  = armed & (begin_trace ? (fifo_full | (fifo_push &
                     (fifo_valid_words == FIFO_FULL_CNT - 4'h1))) : trigger_event); // R13

  // Next control value from bus write and run completion
  always_comb
  begin
    ctl_next = debug_control_reg;
    if (wr_ctl)
    begin
      ctl_next = writedata[7:0];                          // R6
      if (sec_s2_reg && !debug_control_reg[BIT_MODULE_ON])
        ctl_next[BIT_MODULE_ON] = 1'b0;                   // R7
      if (!ctl_next[BIT_MODULE_ON])
        ctl_next[BIT_RUN_ARM] = 1'b0;                     // R9
    end
    else if (run_done)
      ctl_next[BIT_RUN_ARM] = 1'b0;                       // R8
  end

  // Control register
  always_ff @(posedge clock)
  begin
    if (rst)
      debug_control_reg <= CONTROL_RESET;
    else
      debug_control_reg <= ctl_next;
  end

  // Match flags and valid count; arming clears them
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cmp_a_match_flag <= 1'b0;
      cmp_b_match_flag <= 1'b0;
      fifo_valid_words <= 4'h0;
    end
    else if (wr_ctl && ctl_next[BIT_RUN_ARM] && !debug_control_reg[BIT_RUN_ARM])
    begin
      cmp_a_match_flag <= 1'b0; // R19
      cmp_b_match_flag <= 1'b0; // R19
      fifo_valid_words <= 4'h0; // R19
    end
    else if (armed)
    begin
      if (a_q)
        cmp_a_match_flag <= 1'b1;
      if (b_q)
        cmp_b_match_flag <= 1'b1;
      if (fifo_push && !fifo_full)
        fifo_valid_words <= fifo_valid_words + 4'h1; // R12
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus read data
  always_ff @(posedge clock)
  begin
    if (rst)
      readdata <= 32'h0000_0000;
    else if (read && !ack_reg)
    begin
      unique case (address)
        OFS_CONTROL:  readdata <= {24'h0, debug_control_reg};
        OFS_STATUS:   readdata <= {24'h0, cmp_a_match_flag, cmp_b_match_flag,
                                   armed, 1'b0, fifo_valid_words};
        OFS_SECURITY: readdata <= {31'h0, sec_s2_reg};
        default:      readdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparator and FIFO outputs; storage runs regardless of break gate
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cmp_a_hit     <= 1'b0;
      cmp_b_hit     <= 1'b0;
      fifo_store_en <= 1'b0;
    end
    else
    begin
      cmp_a_hit     <= a_q;
      cmp_b_hit     <= b_q;
      fifo_store_en <= armed; // R12
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Break requests; opcode fetch select is not consulted here
  assign brk_cause = run_done & debug_control_reg[BIT_BRK_GATE]; // R11 R14

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      break_force           <= 1'b0;
      break_tag             <= 1'b0;
      software_interrupt_op <= 1'b0;
    end
    else
    begin
      break_force <= brk_cause & ~debug_control_reg[BIT_TAG_SEL]; // R10 R20
      break_tag   <= brk_cause &  debug_control_reg[BIT_TAG_SEL]; // R10 R20
      software_interrupt_op <= brk_cause & ~bg_sc[BIT_BG_PERMIT]; // R21
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_no_break_gated: assert property (@(posedge clock) disable iff (rst) // R11
    !debug_control_reg[BIT_BRK_GATE] |=> !(break_force || break_tag))
    else $error("break issued while gate closed");

  a_break_kind: assert property (@(posedge clock) disable iff (rst) // R10
    brk_cause |=> (break_tag == $past(debug_control_reg[BIT_TAG_SEL]))
                  && (break_force != break_tag))
    else $error("wrong break kind");

  a_run_clears: assert property (@(posedge clock) disable iff (rst) // R8
    run_done && !wr_ctl |=> !debug_control_reg[BIT_RUN_ARM])
    else $error("run did not end");

  a_stop_on_zero: assert property (@(posedge clock) disable iff (rst) // R9
    wr_ctl && !writedata[BIT_RUN_ARM] |=> !armed)
    else $error("run not stopped");

  a_secure_block: assert property (@(posedge clock) disable iff (rst) // R7
    sec_s2_reg && !debug_control_reg[BIT_MODULE_ON] && !$past(rst)
      |=> !debug_control_reg[BIT_MODULE_ON])
    else $error("module enabled while secured");

  a_arm_clears: assert property (@(posedge clock) disable iff (rst) // R19
    wr_ctl && ctl_next[BIT_RUN_ARM] && !debug_control_reg[BIT_RUN_ARM]
      |=> fifo_valid_words == 4'h0 && !cmp_a_match_flag && !cmp_b_match_flag)
    else $error("arming did not clear status");

  a_ack_timing: assert property (@(posedge clock) disable iff (rst) // R6
    (read || write) && !ack_reg |=> !waitrequest || !(read || write))
    else $error("bus answer late");

  a_swi_break: assert property (@(posedge clock) disable iff (rst) // R21
    software_interrupt_op |-> break_force || break_tag)
    else $error("software interrupt without break");

  a_cmp_a_plain: assert property (@(posedge clock) disable iff (rst) // R15 R16
    !debug_control_reg[BIT_A_QUALIFY] |-> a_q == cmp_a_raw)
    else $error("comparator A used direction while unqualified");

  a_cmp_b_plain: assert property (@(posedge clock) disable iff (rst) // R17 R18
    !debug_control_reg[BIT_B_QUALIFY] |-> b_q == cmp_b_raw)
    else $error("comparator B used direction while unqualified");

  a_trigger_break: assert property (@(posedge clock) disable iff (rst) // R13
    armed && !begin_trace && trigger_event && debug_control_reg[BIT_BRK_GATE]
      |=> break_force || break_tag)
    else $error("end trace trigger gave no break");

  a_full_break: assert property (@(posedge clock) disable iff (rst) // R13
    armed && begin_trace && fifo_push && debug_control_reg[BIT_BRK_GATE] &&
    fifo_valid_words == FIFO_FULL_CNT - 4'h1 |=> break_force || break_tag)
    else $error("full FIFO gave no break");

endmodule
`default_nettype wire
